// File: hdl/dpsc_regs.vh
`ifndef DPSC_REGS_VH
`define DPSC_REGS_VH

// ****************************************************************
// Serial word layout
// ****************************************************************
`define DPSC_WORD_BITS        24
`define DPSC_CMD_MSB          23
`define DPSC_CMD_LSB          20
`define DPSC_ADDR_MSB         19
`define DPSC_ADDR_LSB         16
`define DPSC_DATA_MSB         15
`define DPSC_DATA_LSB         0
`define DPSC_WIPER_MSB        9
`define DPSC_COUNT_FULL       5'h18

// ****************************************************************
// Command codes
// ****************************************************************
`define DPSC_CMD_NOP          4'h0
`define DPSC_CMD_RECALL_ALT   4'h1
`define DPSC_CMD_SAVE_WIPER   4'h2
`define DPSC_CMD_WRITE_STORE  4'h3
`define DPSC_CMD_HALVE_A      4'h4
`define DPSC_CMD_HALVE_B      4'h5
`define DPSC_CMD_DEC_A        4'h6
`define DPSC_CMD_DEC_B        4'h7
`define DPSC_CMD_RECALL       4'h8
`define DPSC_CMD_READ_STORE   4'h9
`define DPSC_CMD_READ_WIPER   4'hA
`define DPSC_CMD_LOAD_WIPER   4'hB
`define DPSC_CMD_DOUBLE_A     4'hC
`define DPSC_CMD_DOUBLE_B     4'hD
`define DPSC_CMD_INC_A        4'hE
`define DPSC_CMD_INC_B        4'hF

// ****************************************************************
// Wiper codes and reset values
// ****************************************************************
`define DPSC_WIPER_ZERO       10'h000
`define DPSC_WIPER_ONE        10'h001
`define DPSC_WIPER_MID        10'h200
`define DPSC_WIPER_FULL       10'h3FF
`define DPSC_WIPER_ADDR       4'h0
`define DPSC_STORE_INIT       16'h0000
`define DPSC_SHIFT_RESET      24'h00_0000

`endif

// File: hdl/dpsc_sync.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-flop synchroniser for the serial pins
// ****************************************************************
module dpsc_sync
(
    input  wire       clk_in,      // Core clock
    input  wire       reset_in,    // Synchronous reset, active high
    input  wire [2:0] async_in,    // Raw pin levels
    output wire [2:0] sync_out     // Levels safe for core logic
);

    reg [2:0] stage_one;           // First stage, read only by second
    reg [2:0] stage_two;           // Second stage, drives the output

    genvar i;

    // One independent two-flop chain per pin
    generate
        for (i = 0; i < 3; i = i + 1)
        begin : g_bit
            always @(posedge clk_in)
            begin
                if (reset_in)
                begin
                    stage_one[i] <= 1'b1;
                    stage_two[i] <= 1'b1;
                end
                else
                begin
                    stage_one[i] <= async_in[i];
                    stage_two[i] <= stage_one[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage_two;

endmodule // dpsc_sync

`default_nettype wire

// File: hdl/dpsc_decoder.v
// Behaviour
// - Word: command, address, spare, ten data bits
// - Execute only when chip select rises
// - Code 1000 reloads wiper from store
// - Code 1001 returns store word on output
// - Code 1010 returns wiper value on output
// - Code 1011 loads ten data bits
// - Code 1100 doubles wiper, +6 dB
// - Code 1101 same as 1100
// - Code 1110 increments, saturating at all ones
// - Code 1111 same as 1110
// - Code 0110 decrements, saturating at zero
// - Code 0111 same as 0110
// - Codes 0100, 0101 halve wiper, stop zero
// - Right shift drops the lowest bit
// - Doubling zero gives code one
// - Doubling midscale or above gives full scale
// - Full scale stays put under doubling
// - Step commands ignore the data bytes
// - Output presents last 24 bits shifted in
// - Word after readback carries selected contents
// - Wiper recalled from store at power-on
// - Store keeps sixteen bits, wiper uses ten
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_regs.vh"

module dpsc_decoder
(
    input  wire       clk_in,                    // Core clock, 20 MHz
    input  wire       reset_in,                  // Synchronous power-on reset
    input  wire       serial_clock_in,           // Link clock from host
    input  wire       chip_select_n_in,          // Frame select, active low
    input  wire       serial_data_in,            // Link data from host
    output reg        serial_readback_out,       // Serial data bit shown
    output reg        serial_readback_oe_n_out,  // Pull low enable, active low
    output reg  [9:0] wiper_register_out,        // Present wiper setting
    output reg        busy_out                   // Power-on recall pending
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    wire [2:0]  pins_sync;           // Synchronised pin levels
    wire        sclk_now;            // Synchronised serial clock
    wire        cs_n_now;            // Synchronised chip select
    wire        sdi_now;             // Synchronised serial data

    reg         sclk_last;           // Serial clock one cycle ago
    reg         cs_n_last;           // Chip select one cycle ago
    wire        sclk_rise;           // Serial clock rising edge
    wire        cs_rise;             // Chip select release edge
    wire        cs_fall;             // Chip select assert edge

    reg  [23:0] shift_word;          // Serial shift register
    reg  [4:0]  bit_count;           // Bits taken, saturating
    reg  [9:0]  wiper_register;      // Volatile wiper setting
    reg  [15:0] nonvolatile_store [0:15]; // Sixteen store words
    reg         recall_pending;      // Power-on recall not yet done

    wire [3:0]  command_code_bits;   // Command field of the word
    wire [3:0]  store_address_bits;  // Address field of the word
    wire [15:0] data_bytes;          // Both data bytes of the word
    wire [9:0]  wiper_data_bits;     // Low ten data bits
    wire        wiper_select_bit;    // Wiper select, one wiper here
    wire        word_complete;       // A full word was shifted in
    wire [9:0]  stored_wiper;        // Wiper part of store word zero
    wire [9:0]  next_wiper;          // Wiper after the command

    integer     k;                   // Store init index

    // ****************************************************************
    // Store contents at configuration time
    // ****************************************************************
    // Nonvolatile words survive reset, so they are only set once
    initial
    begin
        for (k = 0; k < 16; k = k + 1)
        begin
            nonvolatile_store[k] = `DPSC_STORE_INIT;
        end
    end

    // ****************************************************************
    // Wiper update function
    // ****************************************************************
    // New wiper value for a command; the data bytes only reach it
    // through the load command, never through the step commands
    function [9:0] dpsc_step;
        input [3:0] cmd;
        input [9:0] wiper;
        input [9:0] load_value;
        input [9:0] saved_value;
        begin
            case (cmd)
                // Reload from store word zero
                `DPSC_CMD_RECALL,
                `DPSC_CMD_RECALL_ALT:
                begin
                    dpsc_step = saved_value;
                end
                // Direct load of ten data bits
                `DPSC_CMD_LOAD_WIPER:
                begin
                    dpsc_step = load_value;
                end
                // Doubling with the two corner cases
                `DPSC_CMD_DOUBLE_A,
                `DPSC_CMD_DOUBLE_B:
                begin
                    if (wiper == `DPSC_WIPER_ZERO)
                    begin
                        dpsc_step = `DPSC_WIPER_ONE;
                    end
                    else if (wiper >= `DPSC_WIPER_MID)
                    begin
                        dpsc_step = `DPSC_WIPER_FULL;
                    end
                    else
                    begin
                        dpsc_step = {wiper[8:0], 1'b0};
                    end
                end
                // Halving, lowest bit lost, zero stays zero
                `DPSC_CMD_HALVE_A,
                `DPSC_CMD_HALVE_B:
                begin
                    dpsc_step = {1'b0, wiper[9:1]};
                end
                // Increment, held at full scale
                `DPSC_CMD_INC_A,
                `DPSC_CMD_INC_B:
                begin
                    if (wiper == `DPSC_WIPER_FULL)
                    begin
                        dpsc_step = wiper;
                    end
                    else
                    begin
                        dpsc_step = wiper + `DPSC_WIPER_ONE;
                    end
                end
                // Decrement, held at zero
                `DPSC_CMD_DEC_A,
                `DPSC_CMD_DEC_B:
                begin
                    if (wiper == `DPSC_WIPER_ZERO)
                    begin
                        dpsc_step = wiper;
                    end
                    else
                    begin
                        dpsc_step = wiper - `DPSC_WIPER_ONE;
                    end
                end
                // All other codes leave the wiper alone
                default:
                begin
                    dpsc_step = wiper;
                end
            endcase
        end
    endfunction

    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************
    dpsc_sync u_sync
    (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .async_in ({serial_data_in, chip_select_n_in, serial_clock_in}),
        .sync_out (pins_sync)
    );

    assign sclk_now = pins_sync[0];
    assign cs_n_now = pins_sync[1];
    assign sdi_now  = pins_sync[2];

    // Previous levels for edge finding; reset levels match the
    // synchroniser's, so no false edge appears after reset
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sclk_last <= 1'b1;
            cs_n_last <= 1'b1;
        end
        else
        begin
            sclk_last <= sclk_now;
            cs_n_last <= cs_n_now;
        end
    end

    // Data taken on rising serial clock inside a frame
    assign sclk_rise = sclk_now & ~sclk_last & ~cs_n_now;
    assign cs_rise   = cs_n_now & ~cs_n_last;
    assign cs_fall   = ~cs_n_now & cs_n_last;

    // ****************************************************************
    // Word field decode
    // ****************************************************************
    assign command_code_bits  = shift_word[`DPSC_CMD_MSB:`DPSC_CMD_LSB];
    assign store_address_bits = shift_word[`DPSC_ADDR_MSB:`DPSC_ADDR_LSB];
    assign data_bytes         = shift_word[`DPSC_DATA_MSB:`DPSC_DATA_LSB];
    assign wiper_data_bits    = shift_word[`DPSC_WIPER_MSB:`DPSC_DATA_LSB];
    assign wiper_select_bit   = shift_word[`DPSC_ADDR_LSB];
    assign word_complete      = (bit_count == `DPSC_COUNT_FULL);
    assign stored_wiper       = nonvolatile_store[`DPSC_WIPER_ADDR][`DPSC_WIPER_MSB:0];
    assign next_wiper         = dpsc_step(command_code_bits, wiper_register,
                                          wiper_data_bits, stored_wiper);

    // ****************************************************************
    // Shift register and bit counter
    // ****************************************************************
    // MSB first; extra bits in a chain push older bits out the top.
    // On release the readback commands overwrite the data bytes
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            shift_word <= `DPSC_SHIFT_RESET;
            bit_count  <= 5'h00;
        end
        else if (cs_fall)
        begin
            // New frame restarts the count, keeps loaded contents
            bit_count <= 5'h00;
        end
        else if (sclk_rise)
        begin
            shift_word <= {shift_word[22:0], sdi_now};
            if (!word_complete)
            begin
                bit_count <= bit_count + 5'h01;
            end
        end
        else if (cs_rise && word_complete)
        begin
            // Returned contents go out in the following word
            case (command_code_bits)
                `DPSC_CMD_READ_STORE:
                begin
                    shift_word[`DPSC_DATA_MSB:`DPSC_DATA_LSB] <=
                        nonvolatile_store[store_address_bits];
                end
                `DPSC_CMD_READ_WIPER:
                begin
                    shift_word[`DPSC_DATA_MSB:`DPSC_DATA_LSB] <=
                        {6'h00, wiper_register};
                end
                default:
                begin
                    shift_word <= shift_word;
                end
            endcase
        end
    end

    // ****************************************************************
    // Wiper register
    // ****************************************************************
    // Power-on recall first, then commands at chip select release
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            wiper_register <= `DPSC_WIPER_ZERO;
            recall_pending <= 1'b1;
        end
        else if (recall_pending)
        begin
            wiper_register <= stored_wiper;
            recall_pending <= 1'b0;
        end
        else if (cs_rise && word_complete)
        begin
            wiper_register <= next_wiper;
        end
    end

    // ****************************************************************
    // Nonvolatile store writes
    // ****************************************************************
    // No reset: contents persist; save keeps the six upper bits
    always @(posedge clk_in)
    begin
        if (!reset_in && !recall_pending && cs_rise && word_complete)
        begin
            case (command_code_bits)
                `DPSC_CMD_WRITE_STORE:
                begin
                    nonvolatile_store[store_address_bits] <= data_bytes;
                end
                `DPSC_CMD_SAVE_WIPER:
                begin
                    nonvolatile_store[`DPSC_WIPER_ADDR][`DPSC_WIPER_MSB:0] <=
                        wiper_register;
                end
                default:
                begin
                    nonvolatile_store[`DPSC_WIPER_ADDR] <=
                        nonvolatile_store[`DPSC_WIPER_ADDR];
                end
            endcase
        end
    end

    // ****************************************************************
    // Output registers
    // ****************************************************************
    // Open-drain style: pull low for a zero bit, release for a one.
    // Released entirely while chip select is high
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            serial_readback_out      <= 1'b1;
            serial_readback_oe_n_out <= 1'b1;
            wiper_register_out       <= `DPSC_WIPER_ZERO;
            busy_out                 <= 1'b1;
        end
        else
        begin
            serial_readback_out      <= shift_word[23];
            serial_readback_oe_n_out <= cs_n_now | shift_word[23];
            wiper_register_out       <= wiper_register;
            busy_out                 <= recall_pending;
        end
    end

endmodule // dpsc_decoder

`default_nettype wire

// File: sim/dpsc_decoder_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Port checker for the serial command decoder
// ****************************************************************
module dpsc_decoder_sva
(
    input wire logic       clk_in,                    // Core clock
    input wire logic       reset_in,                  // Synchronous reset
    input wire logic       chip_select_n_in,          // Frame select, active low
    input wire logic       serial_readback_out,       // Bit shown on pin
    input wire logic       serial_readback_oe_n_out,  // Pull-low enable, active low
    input wire logic [9:0] wiper_register_out,        // Wiper setting
    input wire logic       busy_out                   // Recall pending
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    // ****************************************************************
    // Named sequences
    // ****************************************************************
    sequence s_link_idle;
        chip_select_n_in [*5];
    endsequence

    sequence s_out_of_reset;
        $fell(reset_in);
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_reset_state: assert property (s_out_of_reset |-> busy_out && serial_readback_oe_n_out
        && wiper_register_out == 10'h000) else $error("outputs not at reset values");
    a_busy_clears: assert property (s_out_of_reset |-> ##[0:4] !busy_out)
        else $error("power-on recall did not finish");
    a_busy_stays_low: assert property (!busy_out |=> !busy_out)
        else $error("busy rose outside reset");
    a_exec_on_cs: assert property (($changed(wiper_register_out) && !$past(busy_out))
        |-> $past(chip_select_n_in, 3) && $past(chip_select_n_in, 4)) else $error("wiper moved inside frame");
    a_wiper_quiet_frame: assert property (!chip_select_n_in [*6] |-> $stable(wiper_register_out))
        else $error("wiper changed while selected");
    a_oe_idle_high: assert property (s_link_idle |-> serial_readback_oe_n_out)
        else $error("pin pulled low while deselected");
    a_oe_pulls_zero: assert property (!serial_readback_oe_n_out |-> !serial_readback_out)
        else $error("pin enabled on a one bit");
    a_shift_held_idle: assert property ((chip_select_n_in && !busy_out) [*8]
        |-> $stable(serial_readback_out)) else $error("shift moved while deselected");
endmodule // dpsc_decoder_sva

`default_nettype wire

// File: sim/dpsc_host.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host controller model on the serial link
// ****************************************************************
module dpsc_host
(
    input  wire logic clk_in,             // Core clock, pacing only
    output var  logic serial_clock_out,   // Link clock, idle low
    output var  logic chip_select_n_out,  // Frame select, active low
    output var  logic serial_data_out,    // Link data to decoder
    input  wire logic readback_line_in    // Pulled-up readback pin
);
    // Idle link at time zero
    initial
    begin
        serial_clock_out  = 1'b0;
        chip_select_n_out = 1'b1;
        serial_data_out   = 1'b0;
    end

    // One frame of nbits, MSB first, 400 ns link clock
    task automatic xfer(input logic [47:0] word, input int nbits, output logic [23:0] back);
        int i;
        begin
            back = 24'h00_0000;
            @(negedge clk_in);
            chip_select_n_out = 1'b0;
            for (i = nbits - 1; i >= 0; i--)
            begin
                serial_data_out = word[i];
                repeat (4) @(negedge clk_in);
                back = {back[22:0], readback_line_in}; // Sampled before rising edge
                serial_clock_out = 1'b1;
                repeat (4) @(negedge clk_in);
                serial_clock_out = 1'b0;
            end
            repeat (4) @(negedge clk_in);
            chip_select_n_out = 1'b1;
            serial_data_out   = ~serial_data_out; // Released line shows no stale bit
            repeat (10) @(negedge clk_in);
        end
    endtask
endmodule // dpsc_host

`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_regs.vh"

// ****************************************************************
// Bench top
// ****************************************************************
module tb_top;
    logic        clk_in          = 1'b0;  // Core clock
    logic        reset_in        = 1'b1;  // Power-on reset
    wire         serial_clock;            // Link clock
    wire         chip_select_n;           // Frame select, active low
    wire         serial_data;             // Link data
    wire         readback_bit;            // Decoder output bit
    wire         readback_oe_n;           // Pull-low enable, active low
    wire         readback_line;           // Pin with pull-up
    wire  [9:0]  wiper;                   // Wiper setting
    wire         busy;                    // Recall pending
    logic [23:0] back_word;               // Bits returned by last frame
    int          fails           = 0;     // Mismatches
    int          samples_checked = 0;     // Comparisons

    always #25 clk_in = ~clk_in;

    // Pull-up wins when released
    assign readback_line = readback_oe_n ? 1'b1 : readback_bit;

    dpsc_decoder DUT
    (
        .clk_in                   (clk_in),
        .reset_in                 (reset_in),
        .serial_clock_in          (serial_clock),
        .chip_select_n_in         (chip_select_n),
        .serial_data_in           (serial_data),
        .serial_readback_out      (readback_bit),
        .serial_readback_oe_n_out (readback_oe_n),
        .wiper_register_out       (wiper),
        .busy_out                 (busy)
    );

    dpsc_host host
    (
        .clk_in            (clk_in),
        .serial_clock_out  (serial_clock),
        .chip_select_n_out (chip_select_n),
        .serial_data_out   (serial_data),
        .readback_line_in  (readback_line)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] expected);
        samples_checked++;
        if (seen !== expected)
        begin
            fails++;
            $display("FAIL at %0t ns: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Reset for 5 cycles, then bounded wait for recall
    task automatic do_reset;
        int n;
        begin
            @(negedge clk_in);
            reset_in = 1'b1;
            repeat (5) @(negedge clk_in);
            reset_in = 1'b0;
            n = 0;
            while (busy !== 1'b0 && n < 20)
            begin
                @(negedge clk_in);
                n++;
            end
            if (n >= 20)
            begin
                fails++;
                test_done();
            end
            repeat (4) @(negedge clk_in);
        end
    endtask

    // One full 24-bit command word
    task automatic cmd(input logic [3:0] code, input logic [3:0] addr, input logic [15:0] data);
        host.xfer({24'h00_0000, code, addr, data}, 24, back_word);
    endtask

    // Preset wiper, apply one step command with all data bits set
    task automatic step(input logic [3:0] code, input logic [3:0] addr, input logic [9:0] start,
                        input logic [9:0] expected);
        cmd(`DPSC_CMD_LOAD_WIPER, 4'h0, {6'h00, start});
        cmd(code, addr, 16'hFFFF);
        check({14'h0000, wiper}, {14'h0000, expected});
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_load;
        check({14'h0000, wiper}, 24'h00_0000);
        cmd(`DPSC_CMD_LOAD_WIPER, 4'h0, 16'hFD55);
        check({14'h0000, wiper}, 24'h00_0155);
        host.xfer({24'h00_0000, 24'hB0_02AA}, 23, back_word);
        check({14'h0000, wiper}, 24'h00_0155);
        $display("test load done");
    endtask

    task automatic t_steps;
        step(`DPSC_CMD_DOUBLE_A, 4'h0, 10'h000, 10'h001);
        step(`DPSC_CMD_DOUBLE_B, 4'hF, 10'h005, 10'h00A);
        step(`DPSC_CMD_DOUBLE_A, 4'h0, 10'h200, 10'h3FF);
        step(`DPSC_CMD_DOUBLE_B, 4'h0, 10'h3FF, 10'h3FF);
        step(`DPSC_CMD_DOUBLE_A, 4'h0, 10'h1FF, 10'h3FE);
        step(`DPSC_CMD_INC_A, 4'h0, 10'h3FE, 10'h3FF);
        step(`DPSC_CMD_INC_B, 4'h7, 10'h3FF, 10'h3FF);
        step(`DPSC_CMD_DEC_A, 4'h0, 10'h000, 10'h000);
        step(`DPSC_CMD_DEC_B, 4'h9, 10'h200, 10'h1FF);
        step(`DPSC_CMD_HALVE_A, 4'h0, 10'h007, 10'h003);
        step(`DPSC_CMD_HALVE_B, 4'h3, 10'h001, 10'h000);
        step(`DPSC_CMD_HALVE_A, 4'h0, 10'h000, 10'h000);
        $display("test steps done");
    endtask

    task automatic t_readback;
        cmd(`DPSC_CMD_LOAD_WIPER, 4'h0, 16'h02A5);
        cmd(`DPSC_CMD_READ_WIPER, 4'h0, 16'h0000);
        cmd(`DPSC_CMD_NOP, 4'h0, 16'h0000);
        check({14'h0000, back_word[9:0]}, 24'h00_02A5);
        check({16'h0000, back_word[23:16]}, 24'h00_00A0);
        cmd(`DPSC_CMD_WRITE_STORE, 4'h5, 16'hBEEF);
        cmd(`DPSC_CMD_READ_STORE, 4'h5, 16'h0000);
        cmd(`DPSC_CMD_NOP, 4'h0, 16'h0000);
        check({8'h00, back_word[15:0]}, 24'h00_BEEF);
        check({16'h0000, back_word[23:16]}, 24'h00_0095);
        $display("test readback done");
    endtask

    task automatic t_daisy;
        host.xfer({24'hB0_0111, 24'hB0_0222}, 48, back_word);
        check({14'h0000, wiper}, 24'h00_0222);
        check(back_word, 24'hB0_0111);
        $display("test daisy done");
    endtask

    task automatic t_recall;
        cmd(`DPSC_CMD_WRITE_STORE, `DPSC_WIPER_ADDR, 16'hFC55);
        cmd(`DPSC_CMD_LOAD_WIPER, 4'h0, 16'h0000);
        cmd(`DPSC_CMD_RECALL, 4'h0, 16'h0000);
        check({14'h0000, wiper}, 24'h00_0055);
        cmd(`DPSC_CMD_LOAD_WIPER, 4'h0, 16'h0000);
        do_reset();
        check({14'h0000, wiper}, 24'h00_0055);
        cmd(`DPSC_CMD_LOAD_WIPER, 4'h0, 16'h01AB);
        cmd(`DPSC_CMD_SAVE_WIPER, 4'h0, 16'h0000);
        cmd(`DPSC_CMD_LOAD_WIPER, 4'h0, 16'h0000);
        cmd(`DPSC_CMD_RECALL_ALT, 4'h0, 16'h0000);
        check({14'h0000, wiper}, 24'h00_01AB);
        cmd(`DPSC_CMD_READ_STORE, `DPSC_WIPER_ADDR, 16'h0000);
        cmd(`DPSC_CMD_NOP, 4'h0, 16'h0000);
        check({8'h00, back_word[15:0]}, 24'h00_FDAB);
        $display("test recall done");
    endtask

    // Main sequence
    initial
    begin
        do_reset();
        t_load();
        t_steps();
        t_readback();
        t_daisy();
        t_recall();
        test_done();
    end
endmodule // tb_top

bind dpsc_decoder dpsc_decoder_sva u_sva
(
    .clk_in                   (clk_in),
    .reset_in                 (reset_in),
    .chip_select_n_in         (chip_select_n_in),
    .serial_readback_out      (serial_readback_out),
    .serial_readback_oe_n_out (serial_readback_oe_n_out),
    .wiper_register_out       (wiper_register_out),
    .busy_out                 (busy_out)
);

`default_nettype wire
